// File: design/wcm_top.sv
`timescale 1ns/1ps
`default_nettype none
module wcm_top (
  input  wire logic              I_MCLK,
  input  wire logic              I_RESET_N,
  input  wire wcm_pkg::wcm_cfg_t I_CFG,
  input  wire logic              I_LFOSC,
  input  wire logic              I_DEV_CLK,
  input  wire logic              I_PRI_OSC,
  input  wire logic              I_PIN_RST,
  input  wire logic              I_POWER_UP_TIMER_DONE,
  input  wire logic              I_SLEEP_INSTR,
  input  wire logic              I_WAKE,
  input  wire logic              I_WDT_CLR,
  input  wire logic              I_NEW_OSC_WR,
  input  wire logic              I_NEW_OSC_INT,
  input  wire logic [2:0]        I_IRCF,
  input  wire logic [3:0]        I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [3:0]        I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  output logic                   O_WDT_RESET,
  output logic                   O_OSC_FAIL_FLAG,
  output logic                   O_CLK_SEL_INT,
  output logic                   O_COSC_PRIMARY,
  output logic                   O_CPU_RUN,
  output logic                   O_LFOSC_EN
);

  function automatic logic rise_of(input logic now, input logic old);
    rise_of = now & ~old;
  endfunction

  // Pin synchronisers: stage 1 feeds stage 2, stage 2 feeds stage 3 for edges
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= {I_PIN_RST, I_PRI_OSC, I_DEV_CLK, I_LFOSC};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire lf_rise   = rise_of(sync2_r[0], sync3_r[0]);
  wire dev_fall  = rise_of(sync3_r[1], sync2_r[1]);
  wire pri_rise  = rise_of(sync2_r[2], sync3_r[2]);
  wire pin_rise  = rise_of(sync2_r[3], sync3_r[3]);

  // Sample clock divider on the low-frequency oscillator
  logic [5:0] samp_div_r;
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) samp_div_r <= 6'h0;
    else if (lf_rise) samp_div_r <= samp_div_r + 6'h1;
  end
  wire samp_rise = lf_rise & (samp_div_r == wcm_pkg::SAMPLE_HALF);
  wire samp_fall = lf_rise & (samp_div_r == wcm_pkg::SAMPLE_LAST);

  // Clock state
  wcm_pkg::wcm_clk_state_t state_r;
  wcm_pkg::wcm_clk_state_t state_nxt;
  logic [11:0] ost_cnt_r;
  logic        cm_latch_r;

  // Internal oscillator failure is not observable here: only
  // external sources are watched, and only once running on them
  wire mon_src = (state_r == wcm_pkg::S_PRI) |
                 ((state_r == wcm_pkg::S_PM) & ~I_NEW_OSC_INT);
  wire mon_en    = ~I_CFG.clock_fail_monitor_off & mon_src;
  wire clk_fail  = mon_en & samp_fall & cm_latch_r;
  wire ost_done  = pri_rise & (ost_cnt_r == wcm_pkg::OST_LAST);

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) cm_latch_r <= 1'b0;
    else if (dev_fall) cm_latch_r <= 1'b1;
    else if (samp_rise) cm_latch_r <= 1'b0;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      wcm_pkg::S_POWER_UP_TIMER: begin
        if (I_POWER_UP_TIMER_DONE) state_nxt = wcm_pkg::S_START;
      end
      wcm_pkg::S_START: begin
        if (I_SLEEP_INSTR) state_nxt = wcm_pkg::S_SLEEP;
        else if (I_NEW_OSC_WR) state_nxt = wcm_pkg::S_PM;
        else if (ost_done) state_nxt = wcm_pkg::S_PRI;
      end
      wcm_pkg::S_PRI, wcm_pkg::S_FAIL, wcm_pkg::S_PM: begin
        if (clk_fail) state_nxt = wcm_pkg::S_FAIL;
        else if (I_SLEEP_INSTR) state_nxt = wcm_pkg::S_SLEEP;
        else if (I_NEW_OSC_WR) state_nxt = wcm_pkg::S_PM;
      end
      wcm_pkg::S_SLEEP: begin
        if (I_WAKE) state_nxt = wcm_pkg::S_START;
      end
      default: state_nxt = wcm_pkg::S_POWER_UP_TIMER;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) state_r <= wcm_pkg::S_POWER_UP_TIMER;
    else state_r <= state_nxt;
  end

  // Primary may never start: the counter then just waits
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) ost_cnt_r <= 12'h0;
    else if (state_r != wcm_pkg::S_START) ost_cnt_r <= 12'h0;
    else if (pri_rise) ost_cnt_r <= ost_cnt_r + 12'h1;
  end

  // Registered clock outputs from the next state
  wire pm_pri     = (state_nxt == wcm_pkg::S_PM) & ~I_NEW_OSC_INT;
  wire on_pri_nxt = (state_nxt == wcm_pkg::S_PRI) | pm_pri;
  // Fail-safe keeps status showing the primary, by design
  wire cosc_nxt   = on_pri_nxt | (state_nxt == wcm_pkg::S_FAIL);
  wire halt_nxt   = (state_nxt == wcm_pkg::S_POWER_UP_TIMER) |
                    (state_nxt == wcm_pkg::S_SLEEP) |
                    ((state_nxt == wcm_pkg::S_START) &
                     ~I_CFG.dual_speed_startup_enable);
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CLK_SEL_INT  <= 1'b1;
      O_COSC_PRIMARY <= 1'b0;
      O_CPU_RUN      <= 1'b0;
    end else begin
      O_CLK_SEL_INT  <= ~on_pri_nxt;
      O_COSC_PRIMARY <= cosc_nxt;
      O_CPU_RUN      <= ~halt_nxt;
    end
  end

  // Registers
  logic       sw_wdt_on_r;
  logic       pin_reset_flag_r;
  logic       osc_fail_flag_r;
  logic [2:0] ircf_r;

  // Watchdog enable
  logic wdt_en;
  always_comb begin
    case (I_CFG.watchdog_mode_field)
      wcm_pkg::WDT_MODE_ON:     wdt_en = 1'b1;
      wcm_pkg::WDT_MODE_SW:     wdt_en = sw_wdt_on_r;
      wcm_pkg::WDT_MODE_ACTIVE: wdt_en = state_r != wcm_pkg::S_SLEEP;
      default:                  wdt_en = 1'b0;
    endcase
  end

  // Watchdog counters
  logic [6:0]  base_cnt_r;
  logic [15:0] ps_cnt_r;
  wire [15:0] term     = 16'h1 << I_CFG.postscale_select;
  wire [15:0] term_m1  = term - 16'h1;
  wire [15:0] win_at   = (term >> 1) + (term >> 2);
  wire        windowed = ~I_CFG.window_disable_bit;
  wire        win_open = ps_cnt_r >= win_at;
  wire        early    = wdt_en & windowed & I_WDT_CLR & ~win_open;
  wire        base_tick = lf_rise & (base_cnt_r == wcm_pkg::WDT_BASE_LAST);
  wire        timeout  = wdt_en & base_tick & (ps_cnt_r == term_m1);
  wire        clr_ok   = I_WDT_CLR & ~early;
  wire        wdt_clr  = I_SLEEP_INSTR | clr_ok | early | timeout |
                         (I_IRCF != ircf_r) | clk_fail | ~wdt_en;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      base_cnt_r <= 7'h0;
      ps_cnt_r   <= 16'h0;
    end else if (wdt_clr) begin
      base_cnt_r <= 7'h0;
      ps_cnt_r   <= 16'h0;
    end else if (base_tick) begin
      base_cnt_r <= 7'h0;
      ps_cnt_r   <= ps_cnt_r + 16'h1;
    end else if (lf_rise) begin
      base_cnt_r <= base_cnt_r + 7'h1;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_WDT_RESET <= 1'b0;
      ircf_r      <= 3'h0;
      O_LFOSC_EN  <= 1'b0;
    end else begin
      O_WDT_RESET <= timeout | early;
      ircf_r      <= I_IRCF;
      O_LFOSC_EN  <= wdt_en | ~I_CFG.clock_fail_monitor_off;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic       aw_got_r;
  logic       w_got_r;
  logic [3:0] awaddr_r;
  logic [7:0] wdata_r;
  logic       wstrb0_r;
  assign O_AWREADY = ~aw_got_r & ~O_BVALID;
  assign O_WREADY  = ~w_got_r & ~O_BVALID;
  wire aw_fire = I_AWVALID & O_AWREADY;
  wire w_fire  = I_WVALID & O_WREADY;
  wire have_aw = aw_got_r | aw_fire;
  wire have_w  = w_got_r | w_fire;
  wire do_wr   = have_aw & have_w;
  wire [3:0] wr_addr = aw_got_r ? awaddr_r : I_AWADDR;
  wire [7:0] wr_data = w_got_r ? wdata_r : I_WDATA[7:0];
  wire       wr_lane = w_got_r ? wstrb0_r : I_WSTRB[0];
  wire wr_ctrl = do_wr & wr_lane &
                 (wr_addr == wcm_pkg::REG_RESET_CTRL2_OFS);
  wire wr_stat = do_wr & wr_lane & (wr_addr == wcm_pkg::REG_STATUS_OFS);
  wire wr_hit  = (wr_addr == wcm_pkg::REG_RESET_CTRL2_OFS) |
                 (wr_addr == wcm_pkg::REG_STATUS_OFS);

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r  <= 8'h0;
      wstrb0_r <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP  <= wcm_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) awaddr_r <= I_AWADDR;
      if (w_fire) begin
        wdata_r  <= I_WDATA[7:0];
        wstrb0_r <= I_WSTRB[0];
      end
      aw_got_r <= have_aw & ~do_wr;
      w_got_r  <= have_w & ~do_wr;
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_hit ? wcm_pkg::RESP_OKAY : wcm_pkg::RESP_SLVERR;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Hardware sets win over software clears
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sw_wdt_on_r      <= wcm_pkg::RESET_CTRL2_RST[wcm_pkg::SW_WDT_ON_BIT];
      pin_reset_flag_r <=
        wcm_pkg::RESET_CTRL2_RST[wcm_pkg::PIN_RESET_FLAG_BIT];
      osc_fail_flag_r  <= 1'b0;
    end else begin
      if (wr_ctrl) sw_wdt_on_r <= wr_data[wcm_pkg::SW_WDT_ON_BIT];
      if (pin_rise) pin_reset_flag_r <= 1'b1;
      else if (wr_ctrl & ~wr_data[wcm_pkg::PIN_RESET_FLAG_BIT])
        pin_reset_flag_r <= 1'b0;
      if (clk_fail) osc_fail_flag_r <= 1'b1;
      else if (wr_stat & wr_data[wcm_pkg::OSC_FAIL_FLAG_BIT])
        osc_fail_flag_r <= 1'b0;
    end
  end
  assign O_OSC_FAIL_FLAG = osc_fail_flag_r;

  // AXI4-Lite read path
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h0;
    case (I_ARADDR)
      wcm_pkg::REG_RESET_CTRL2_OFS: begin
        rd_data[wcm_pkg::PIN_RESET_FLAG_BIT] = pin_reset_flag_r;
        rd_data[wcm_pkg::SW_WDT_ON_BIT]      = sw_wdt_on_r;
      end
      wcm_pkg::REG_STATUS_OFS: begin
        rd_data[wcm_pkg::OSC_FAIL_FLAG_BIT] = osc_fail_flag_r;
        rd_data[wcm_pkg::ON_INTERNAL_BIT]   = O_CLK_SEL_INT;
        rd_data[wcm_pkg::WDT_RUNNING_BIT]   = wdt_en;
        rd_data[wcm_pkg::COSC_PRIMARY_BIT]  = O_COSC_PRIMARY;
      end
      default: rd_data = 8'h0;
    endcase
  end
  wire rd_hit = (I_ARADDR == wcm_pkg::REG_RESET_CTRL2_OFS) |
                (I_ARADDR == wcm_pkg::REG_STATUS_OFS);

  assign O_ARREADY = ~O_RVALID;
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0;
      O_RRESP  <= wcm_pkg::RESP_OKAY;
    end else if (I_ARVALID & O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= {24'h0, rd_data};
      O_RRESP  <= rd_hit ? wcm_pkg::RESP_OKAY : wcm_pkg::RESP_SLVERR;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: design/wcm_pkg.sv
`default_nettype none
package wcm_pkg;

  // Register byte offsets
  localparam logic [3:0] REG_RESET_CTRL2_OFS = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS      = 4'h4;

  // reset_control_2 field positions and reset value
  localparam int         PIN_RESET_FLAG_BIT = 7;
  localparam int         SW_WDT_ON_BIT      = 5;
  localparam logic [7:0] RESET_CTRL2_RST    = 8'h00;

  // Status register field positions
  localparam int OSC_FAIL_FLAG_BIT = 0;
  localparam int ON_INTERNAL_BIT   = 1;
  localparam int WDT_RUNNING_BIT   = 2;
  localparam int COSC_PRIMARY_BIT  = 3;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Watchdog mode field encodings
  localparam logic [1:0] WDT_MODE_OFF    = 2'h0;
  localparam logic [1:0] WDT_MODE_ACTIVE = 2'h1;
  localparam logic [1:0] WDT_MODE_SW     = 2'h2;
  localparam logic [1:0] WDT_MODE_ON     = 2'h3;

  // Timing: base period in its own unit, ticks derived from the rate
  localparam int WDT_BASE_US    = 4000;
  localparam int LF_OSC_HZ      = 31250;
  localparam int WDT_BASE_TICKS = (WDT_BASE_US * LF_OSC_HZ) / 1000000;
  localparam int SAMPLE_DIV     = 64;
  localparam int OST_PERIODS    = 1024;
  localparam int HANDOVER_PERIODS = 2;

  localparam logic [6:0]  WDT_BASE_LAST =
    7'(WDT_BASE_TICKS - 1);
  localparam logic [11:0] OST_LAST =
    12'(OST_PERIODS + HANDOVER_PERIODS - 1);
  localparam logic [5:0]  SAMPLE_HALF = 6'(SAMPLE_DIV / 2 - 1);
  localparam logic [5:0]  SAMPLE_LAST = 6'(SAMPLE_DIV - 1);

  typedef struct packed {
    logic [1:0] watchdog_mode_field;
    logic       window_disable_bit;
    logic [3:0] postscale_select;
    logic       dual_speed_startup_enable;
    logic       clock_fail_monitor_off;
  } wcm_cfg_t;

  typedef enum logic [2:0] {
    S_POWER_UP_TIMER,
    S_START,
    S_PRI,
    S_FAIL,
    S_SLEEP,
    S_PM
  } wcm_clk_state_t;

endpackage
`default_nettype wire

// File: test/wcm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wcm_chk (
  input wire logic              I_MCLK,
  input wire logic              I_RESET_N,
  input wire wcm_pkg::wcm_cfg_t I_CFG,
  input wire logic              I_WVALID,
  input wire logic              I_BREADY,
  input wire logic              I_ARVALID,
  input wire logic              I_RREADY,
  input wire logic              O_AWREADY,
  input wire logic              O_WREADY,
  input wire logic [1:0]        O_BRESP,
  input wire logic              O_BVALID,
  input wire logic              O_ARREADY,
  input wire logic [31:0]       O_RDATA,
  input wire logic              O_RVALID,
  input wire logic              O_WDT_RESET,
  input wire logic              O_OSC_FAIL_FLAG,
  input wire logic              O_CLK_SEL_INT,
  input wire logic              O_COSC_PRIMARY,
  input wire logic              O_LFOSC_EN
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  property p_rd_lat;
    I_ARVALID && O_ARREADY |=> O_RVALID;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_block;
    O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken early");
  property p_wdt_pulse;
    O_WDT_RESET |=> !O_WDT_RESET;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("reset pulse long");
  property p_wdt_off;
    (I_CFG.watchdog_mode_field == wcm_pkg::WDT_MODE_OFF) [*3] |-> !O_WDT_RESET;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("reset while off");
  // Only a register write may clear the sticky flag
  property p_fail_sticky;
    $fell(O_OSC_FAIL_FLAG) |-> O_BVALID || $past(I_WVALID);
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("flag lost");
  property p_fail_sw;
    $rose(O_OSC_FAIL_FLAG) |-> ##[0:1] (O_CLK_SEL_INT && O_COSC_PRIMARY);
  endproperty
  a_fail_sw: assert property (p_fail_sw) else $error("no fail-safe");
  property p_lf_en;
    !I_CFG.clock_fail_monitor_off [*2] |-> O_LFOSC_EN;
  endproperty
  a_lf_en: assert property (p_lf_en) else $error("osc stopped");
  c_wdt: cover property (O_WDT_RESET);
  c_fail: cover property ($rose(O_OSC_FAIL_FLAG));
  c_read: cover property (O_RVALID && I_RREADY);
endmodule
bind wcm_top wcm_chk i_wcm_chk (
  .I_MCLK, .I_RESET_N, .I_CFG, .I_WVALID, .I_BREADY, .I_ARVALID,
  .I_RREADY, .O_AWREADY, .O_WREADY, .O_BRESP, .O_BVALID, .O_ARREADY,
  .O_RDATA, .O_RVALID, .O_WDT_RESET, .O_OSC_FAIL_FLAG, .O_CLK_SEL_INT,
  .O_COSC_PRIMARY, .O_LFOSC_EN
);
`default_nettype wire

// File: test/wcm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wcm_bench;
  localparam int         BASE = 6 * wcm_pkg::WDT_BASE_TICKS;
  localparam logic [1:0] OK = wcm_pkg::RESP_OKAY;
  localparam logic [1:0] SE = wcm_pkg::RESP_SLVERR;
  localparam logic [3:0] RC = wcm_pkg::REG_RESET_CTRL2_OFS;
  localparam logic [3:0] ST = wcm_pkg::REG_STATUS_OFS;
  localparam logic [7:0] SWB = 8'h01 << wcm_pkg::SW_WDT_ON_BIT;
  localparam logic [7:0] PRB = 8'h01 << wcm_pkg::PIN_RESET_FLAG_BIT;
  localparam logic [7:0] FB = 8'h01 << wcm_pkg::OSC_FAIL_FLAG_BIT;
  localparam logic [7:0] IB = 8'h01 << wcm_pkg::ON_INTERNAL_BIT;
  localparam logic [7:0] CB = 8'h01 << wcm_pkg::COSC_PRIMARY_BIT;
  wcm_pkg::wcm_cfg_t cfg;
  logic        clk, rst_n, lf, dev, pri, pin, power_up_timer, clr, dev_on, pri_on;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        wdt, fail, selint, cosc, run, lfen;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          n_mismatch, tests_run, cyc, n_pulse, t_last, p, t0, k;

  wcm_top i_wcm_top (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_CFG(cfg), .I_LFOSC(lf),
    .I_DEV_CLK(dev), .I_PRI_OSC(pri), .I_PIN_RST(pin),
    .I_POWER_UP_TIMER_DONE(power_up_timer), .I_SLEEP_INSTR(1'b0), .I_WAKE(1'b0),
    .I_WDT_CLR(clr), .I_NEW_OSC_WR(1'b0), .I_NEW_OSC_INT(1'b0),
    .I_IRCF(3'h0), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_WDT_RESET(wdt), .O_OSC_FAIL_FLAG(fail), .O_CLK_SEL_INT(selint),
    .O_COSC_PRIMARY(cosc), .O_CPU_RUN(run), .O_LFOSC_EN(lfen)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Slow oscillator: six clock cycles a period, far above the sync depth
  always begin
    repeat (3) @(posedge clk);
    lf <= ~lf;
  end

  task automatic chk(input string n, input logic [33:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    pri <= pri_on ? cyc[1] : 1'b0;
    dev <= dev_on ? cyc[1] : 1'b0;
    if (wdt) begin
      n_pulse <= n_pulse + 1;
      t_last <= cyc;
    end
    if (rvalid && rready) chk("read", {rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready) chk("bresp", 34'(bresp), 34'(exp_b.pop_front()));
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  // Ready raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= {24'($urandom()), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    exp_r.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic wait_p(input int b);
    p = n_pulse;
    for (int i = 0; i < b && n_pulse == p; i++) @(posedge clk);
  endtask

  task automatic count(input int n);
    k = n_pulse;
    repeat (n) @(posedge clk);
    k = n_pulse - k;
  endtask

  initial begin
    void'($urandom(73933));
    {awvalid, wvalid, bready, arvalid, rready, pin, clr} = '0;
    {lf, dev, pri, dev_on, pri_on, power_up_timer, rst_n} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {n_mismatch, tests_run, cyc, n_pulse, t_last} = '0;
    cfg = {wcm_pkg::WDT_MODE_SW, 1'b1, 4'h0, 1'b1, 1'b0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    power_up_timer <= 1'b1;
    rd(RC, 8'h00, OK);
    rd(4'h8, 8'h00, SE);
    wr(4'h8, 8'hff, 4'hf, SE);
    wr(RC, SWB, 4'hf, OK);
    wr(RC, 8'h00, 4'he, OK);
    rd(RC, SWB, OK);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    rd(RC, SWB | PRB, OK);
    wr(RC, SWB, 4'h1, OK);
    rd(RC, SWB, OK);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      cfg.watchdog_mode_field <= 2'(m);
      repeat (4) @(posedge clk);
      count(2 * BASE + 100);
      chk("wdt mode", 34'(k > 0), 34'(m != 0));
    end
    cfg.watchdog_mode_field <= wcm_pkg::WDT_MODE_SW;
    wr(RC, 8'h00, 4'hf, OK);
    count(2 * BASE + 100);
    chk("wdt sw off", 34'(k), 34'(0));
    $display("test modes done");
    cfg.watchdog_mode_field <= wcm_pkg::WDT_MODE_ON;
    for (int s = 0; s < 3; s++) begin
      cfg.postscale_select <= 4'(s);
      wait_p(8 * BASE);
      wait_p(8 * BASE);
      t0 = t_last;
      wait_p(8 * BASE);
      chk("wdt period", 34'(t_last - t0), 34'(BASE << s));
    end
    $display("test periods done");
    cfg.window_disable_bit <= 1'b0;
    wait_p(8 * BASE);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_p(8);
    chk("early clear", 34'(n_pulse - p), 34'(1));
    // Clear lands past three base ticks of four, inside the window
    repeat (3 * BASE + BASE / 2) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    count(3 * BASE);
    chk("late clear", 34'(k), 34'(0));
    wait_p(2 * BASE);
    chk("restart", 34'(n_pulse - p), 34'(1));
    $display("test window done");
    rst_n <= 1'b0;
    power_up_timer <= 1'b0;
    cfg <= {wcm_pkg::WDT_MODE_OFF, 1'b1, 4'h0, 1'b1, 1'b0};
    // Latch set by device clock falls: a quiet clock leaves it clear
    {pri_on, dev_on} <= 2'b10;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    chk("power_up_timer wait", 34'(run), 34'(0));
    power_up_timer <= 1'b1;
    repeat (2000) @(posedge clk);
    chk("start", 34'({selint, run, cosc}), 34'(3'b110));
    repeat (3000) @(posedge clk);
    chk("primary", 34'({selint, cosc, fail}), 34'(3'b010));
    dev_on <= 1'b1;
    for (int i = 0; i < 1200 && fail !== 1'b1; i++) @(posedge clk);
    chk("fail", 34'({fail, selint, cosc, lfen}), 34'(4'hf));
    rd(ST, FB | IB | CB, OK);
    wr(ST, FB, 4'hf, OK);
    rd(ST, IB | CB, OK);
    $display("test clock fail done");
    close_out();
  end
endmodule
`default_nettype wire
